//--- design/sfic_pkg.sv
// Shared constants, opcodes and carrier types of the serial flash front end
package sfic_pkg;
  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int CLK_MHZ = 100;
  localparam int SW_RESET_US = 300;
  localparam int SW_RESET_CYCLES = SW_RESET_US * CLK_MHZ;
  localparam int POWER_UP_WRITE_DELAY_US = 1000;
  localparam int POWER_UP_WRITE_DELAY_CYCLES = POWER_UP_WRITE_DELAY_US * CLK_MHZ;
  // ---------------------------------------------------------------
  // Opcodes
  // ---------------------------------------------------------------
  localparam logic [7:0] OP_WREN = 8'h06;
  localparam logic [7:0] OP_WRDI = 8'h04;
  localparam logic [7:0] OP_WRSR = 8'h01;
  localparam logic [7:0] OP_PP = 8'h02;
  localparam logic [7:0] OP_QPP = 8'h32;
  localparam logic [7:0] OP_SE = 8'h20;
  localparam logic [7:0] OP_BE32 = 8'h52;
  localparam logic [7:0] OP_BE64 = 8'hD8;
  localparam logic [7:0] OP_CE = 8'hC7;
  localparam logic [7:0] OP_CE_ALT = 8'h60;
  localparam logic [7:0] OP_DPD = 8'hB9;
  localparam logic [7:0] OP_RDPD = 8'hAB;
  localparam logic [7:0] OP_RST_EN = 8'h66;
  localparam logic [7:0] OP_RST = 8'h99;
  localparam logic [7:0] OP_DUAL_OUT = 8'h3B;
  localparam logic [7:0] OP_DUAL_IO = 8'hBB;
  localparam logic [7:0] OP_DUAL_ID = 8'h92;
  localparam logic [7:0] OP_QUAD_OUT = 8'h6B;
  localparam logic [7:0] OP_QUAD_IO = 8'hEB;
  localparam logic [7:0] OP_QUAD_WORD = 8'hE7;
  localparam logic [7:0] OP_QUAD_ID = 8'h94;
  // ---------------------------------------------------------------
  // Lane widths and states
  // ---------------------------------------------------------------
  localparam logic [2:0] LANES_1 = 3'h1;
  localparam logic [2:0] LANES_2 = 3'h2;
  localparam logic [2:0] LANES_4 = 3'h4;
  typedef enum logic [3:0] {
    ST_DESEL = 4'h1,
    ST_OPC = 4'h2,
    ST_DATA = 4'h4,
    ST_IGNORE = 4'h8
  } sfic_state_t;
  typedef struct packed {
    logic sclk;
    logic cs_n;
    logic [3:0] io;
  } sfic_pins_t;
  typedef struct packed {
    logic quad_enable_bit;
    logic pin_func_sel;
    logic srp1;
    logic srp0;
  } sfic_cfg_t;
endpackage : sfic_pkg

//--- design/sfic_top.sv
// Serial flash interface control: pin front end, command gating, pause and resets
`timescale 1ns/1ps
// Operation
// [R1] Works with host clock mode 0 or 3; host uses one of them.
// [R2] Inputs sampled on rising serial clock, outputs change after falling edge.
// [R3] Opcodes 3B, BB, 92 move the data phase onto two lines.
// [R4] Opcodes 6B, EB, E7, 94, 32 use four lines including protect and pause pins.
// [R5] Four-line opcodes run only when quad enable is set.
// [R6] After power-up, no selection until a chip select falling edge is seen.
// [R7] While power-on reset is active, ignore all and stay in reset.
// [R8] Standby when deselected and no internal write cycle runs.
// [R9] Pause with quad and pin select zero: outputs off, clock and input ignored.
// [R10] Pause starts or ends on pause pin change while clock is low.
// [R11] Chip select high during pause resets the interface and abandons the transfer.
// [R12] Opcode 66 then 99 resets the device; instructions refused for 300 us.
// [R13] Pin select bit chooses pause (0) or active-low reset (1) for shared pin.
// [R14] Reset pin low returns to power-on state and accepts no instruction.
// [R15] Quad enable set disables pause and reset; pin is data line 3.
// [R16] Hardware reset overrides every other input and aborts all operations.
// [R17] In deep power-down only the release instruction is accepted.
// [R18] Write-type instructions refused during the power-up write delay.
// [R19] Write latch set by write enable; cleared by disable, resets and writes.
// [R20] Program and erase refused on a protected region.
// [R21] Protect pin low in hardware protection mode blocks status writes.
// [R22] Pause does not stop an internal write already in progress.
// [R23] Pause pin change with clock high takes effect when clock next low.
// [R24] Quad enable set disables protect pin function; pin is data line 2.
module sfic_top #(
  parameter int SW_RESET_CYCLES = sfic_pkg::SW_RESET_CYCLES,
  parameter int POWER_UP_WRITE_DELAY_CYCLES = sfic_pkg::POWER_UP_WRITE_DELAY_CYCLES
) (
  input wire logic clk,
  input wire logic rst,
  input wire sfic_pkg::sfic_pins_t pins,
  input wire sfic_pkg::sfic_cfg_t cfg,
  input wire logic por_active,
  input wire logic write_busy,
  input wire logic region_protected,
  input wire logic tx_enable,
  input wire logic [7:0] tx_byte,
  output logic [3:0] io_out,
  output logic [3:0] io_oe,
  output logic cmd_valid,
  output logic cmd_refused,
  output logic [7:0] cmd_opcode,
  output logic rx_valid,
  output logic [7:0] rx_byte,
  output logic write_latch,
  output logic standby,
  output logic paused,
  output logic in_reset,
  output logic deep_power_down,
  output logic abort_pulse
);
  import sfic_pkg::*;

  if (SW_RESET_CYCLES < 1 || POWER_UP_WRITE_DELAY_CYCLES < 1) begin : g_chk
    $error("Reset and write delay counts must be at least one cycle");
  end

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  function automatic logic [7:0] shift_in(input logic [7:0] sh, input logic [3:0] io,
                                          input logic [2:0] ln);
    case (ln)
      LANES_2: return {sh[5:0], io[1:0]};
      LANES_4: return {sh[3:0], io};
      default: return {sh[6:0], io[0]};
    endcase
  endfunction : shift_in

  function automatic logic [2:0] lanes_of(input logic [7:0] op);
    case (op)
      OP_DUAL_OUT, OP_DUAL_IO, OP_DUAL_ID: return LANES_2;
      OP_QUAD_OUT, OP_QUAD_IO, OP_QUAD_WORD, OP_QUAD_ID, OP_QPP: return LANES_4;
      default: return LANES_1;
    endcase
  endfunction : lanes_of

  function automatic logic is_write_op(input logic [7:0] op);
    case (op)
      OP_WRSR, OP_PP, OP_QPP, OP_SE, OP_BE32, OP_BE64, OP_CE, OP_CE_ALT: return 1'b1;
      default: return 1'b0;
    endcase
  endfunction : is_write_op

  // ---------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------
  sfic_pins_t s1, s2;
  logic d_sclk, d_cs;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      // Select counts as low until the pin is seen high, so a low pin is no edge
      s1 <= '{sclk: 1'b0, cs_n: 1'b0, io: 4'hF}; // [R6]
      s2 <= '{sclk: 1'b0, cs_n: 1'b0, io: 4'hF};
      d_sclk <= 1'b0;
      d_cs <= 1'b0;
    end else begin
      s1 <= pins;
      s2 <= s1;
      d_sclk <= s2.sclk;
      d_cs <= s2.cs_n;
    end
  end

  // ---------------------------------------------------------------
  // Decode
  // ---------------------------------------------------------------
  sfic_state_t state;
  logic armed, last_66, swr_busy;
  logic [31:0] swr_cnt, pu_cnt;
  logic [7:0] sh, txsh;
  logic [3:0] cnt, tcnt;
  logic [2:0] lanes;
  // Quad mode takes the shared pins away from pause, reset and protect
  wire pin_func_on = !cfg.quad_enable_bit; // [R15] [R24]
  wire hw_reset = pin_func_on && cfg.pin_func_sel && !s2.io[3]; // [R13] [R16]
  wire hold_on = pin_func_on && !cfg.pin_func_sel; // [R9] [R13]
  wire rst_int = por_active || hw_reset || swr_busy; // [R7] [R14] [R16]
  wire cs_fall = d_cs && !s2.cs_n; // [R6]
  wire sclk_rise = s2.sclk && !d_sclk; // [R2]
  wire sclk_fall = !s2.sclk && d_sclk; // [R2]
  wire act_rise = sclk_rise && !paused && !s2.cs_n; // [R9]
  wire act_fall = sclk_fall && !paused && !s2.cs_n;
  wire [7:0] op_now = shift_in(sh, s2.io, LANES_1);
  wire op_done = state == ST_OPC && act_rise && cnt == 4'h7;
  wire wp_block = pin_func_on && !cfg.srp1 && cfg.srp0 && !s2.io[2]; // [R21]
  wire wr_latch_need = is_write_op(op_now) && !write_latch;
  // Deep power-down ignores these opcodes too, so the latch keeps its value
  wire latch_clr = !deep_power_down && (op_now == OP_WRDI || is_write_op(op_now)); // [R17] [R19]
  wire refuse = (deep_power_down && op_now != OP_RDPD) // [R17]
    || (pu_cnt != 32'h0000_0000 && (is_write_op(op_now) || op_now == OP_WREN)) // [R18]
    || (lanes_of(op_now) == LANES_4 && !cfg.quad_enable_bit) // [R5]
    || (op_now == OP_WRSR && wp_block) // [R21]
    || (is_write_op(op_now) && op_now != OP_WRSR && region_protected) // [R20]
    || wr_latch_need;
  wire swr_go = op_done && !refuse && op_now == OP_RST && last_66; // [R12]
  wire [3:0] cnt_next = cnt + {1'b0, lanes};
  wire [7:0] tx_cur = (tcnt == 4'h0) ? tx_byte : txsh;
  wire [3:0] lane_mask = (lanes == LANES_4) ? 4'hF : (lanes == LANES_2) ? 4'h3 : 4'h2;

  // ---------------------------------------------------------------
  // Reset counters and selection arming
  // ---------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      swr_cnt <= 32'h0000_0000;
      swr_busy <= 1'b0;
      pu_cnt <= 32'(POWER_UP_WRITE_DELAY_CYCLES);
      armed <= 1'b0;
    end else begin
      if (swr_go) begin
        swr_busy <= 1'b1; // [R12]
        swr_cnt <= 32'(SW_RESET_CYCLES);
      end else if (swr_busy) begin
        swr_cnt <= swr_cnt - 32'h0000_0001;
        swr_busy <= swr_cnt != 32'h0000_0001;
      end
      if (por_active) pu_cnt <= 32'(POWER_UP_WRITE_DELAY_CYCLES); // [R18]
      else if (pu_cnt != 32'h0000_0000) pu_cnt <= pu_cnt - 32'h0000_0001;
      if (por_active) armed <= 1'b0; // [R6]
      else if (cs_fall) armed <= 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // Pause tracking
  // ---------------------------------------------------------------
  // Follows the pause pin only while the clock is low, so a change with clock high waits
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      paused <= 1'b0;
      abort_pulse <= 1'b0;
    end else begin
      abort_pulse <= (paused && s2.cs_n) || (hw_reset && !in_reset); // [R11] [R16]
      if (!hold_on || s2.cs_n || rst_int) paused <= 1'b0; // [R11]
      else if (!s2.sclk) paused <= !s2.io[3]; // [R10] [R23] [R22]
    end
  end

  // ---------------------------------------------------------------
  // Transfer state machine
  // ---------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state <= ST_DESEL;
      sh <= 8'h00;
      cnt <= 4'h0;
      lanes <= LANES_1;
      cmd_valid <= 1'b0;
      cmd_refused <= 1'b0;
      cmd_opcode <= 8'h00;
      rx_valid <= 1'b0;
      rx_byte <= 8'h00;
      last_66 <= 1'b0;
      deep_power_down <= 1'b0;
      write_latch <= 1'b0;
    end else begin
      cmd_valid <= 1'b0;
      cmd_refused <= 1'b0;
      rx_valid <= 1'b0;
      if (rst_int) begin // [R7] [R14] [R16]
        state <= ST_DESEL;
        cnt <= 4'h0;
        last_66 <= 1'b0;
        deep_power_down <= 1'b0;
        write_latch <= 1'b0; // [R19]
      end else if (s2.cs_n) begin // [R11]
        state <= ST_DESEL;
        cnt <= 4'h0;
      end else begin
        case (state)
          ST_DESEL: begin
            lanes <= LANES_1;
            cnt <= 4'h0;
            if (cs_fall && armed) state <= ST_OPC; // [R6] [R1]
            else if (cs_fall) state <= ST_OPC;
          end
          ST_OPC: begin
            if (!armed) begin
              state <= ST_IGNORE; // [R6]
            end else if (act_rise) begin
              sh <= op_now;
              cnt <= cnt + 4'h1;
              if (cnt == 4'h7) begin
                cnt <= 4'h0;
                cmd_opcode <= op_now;
                cmd_valid <= !refuse;
                cmd_refused <= refuse;
                state <= refuse ? ST_IGNORE : ST_DATA;
                lanes <= lanes_of(op_now); // [R3] [R4]
                if (!refuse) last_66 <= op_now == OP_RST_EN; // [R12]
                if (!refuse && op_now == OP_DPD) deep_power_down <= 1'b1; // [R17]
                if (!refuse && op_now == OP_RDPD) deep_power_down <= 1'b0;
                if (!refuse && op_now == OP_WREN) write_latch <= 1'b1; // [R19]
                if (latch_clr) begin
                  write_latch <= 1'b0; // [R19]
                end
              end
            end
          end
          ST_DATA: begin
            if (act_rise) begin
              sh <= shift_in(sh, s2.io, lanes); // [R2] [R3] [R4]
              cnt <= cnt_next;
              if (cnt_next == 4'h8) begin
                cnt <= 4'h0;
                rx_valid <= 1'b1;
                rx_byte <= shift_in(sh, s2.io, lanes);
              end
            end
          end
          ST_IGNORE: state <= ST_IGNORE;
          default: state <= ST_DESEL;
        endcase
      end
    end
  end

  // ---------------------------------------------------------------
  // Output drive and standby
  // ---------------------------------------------------------------
  // Drive changes only after falling edges so the host samples stable data
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      io_out <= 4'h0;
      io_oe <= 4'h0;
      txsh <= 8'h00;
      tcnt <= 4'h0;
      standby <= 1'b1;
      in_reset <= 1'b1;
    end else begin
      standby <= s2.cs_n && !write_busy; // [R8]
      in_reset <= rst_int;
      if (state != ST_DATA || !tx_enable || paused || s2.cs_n || rst_int) begin
        io_oe <= 4'h0; // [R9]
        if (state != ST_DATA) tcnt <= 4'h0;
      end else if (act_fall) begin
        io_oe <= lane_mask; // [R2] [R3] [R4]
        io_out <= (lanes == LANES_4) ? tx_cur[7:4] :
                  (lanes == LANES_2) ? {2'b00, tx_cur[7:6]} : {2'b00, tx_cur[7], 1'b0};
        txsh <= tx_cur << lanes;
        tcnt <= (tcnt + {1'b0, lanes}) & 4'h7;
      end
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  property p_armed; cmd_valid |-> armed; endproperty
  a_armed: assert property (p_armed) else $error("Command before first select edge"); // [R6]
  property p_reset_quiet; in_reset |=> !cmd_valid; endproperty
  a_reset_quiet: assert property (p_reset_quiet) else $error("Command during reset"); // [R7]
  property p_dpd; cmd_valid && $past(deep_power_down) |-> cmd_opcode == OP_RDPD; endproperty
  a_dpd: assert property (p_dpd) else $error("Command taken in deep power-down"); // [R17]
  property p_quad; cmd_valid && lanes_of(cmd_opcode) == LANES_4 |-> cfg.quad_enable_bit;
  endproperty
  a_quad: assert property (p_quad) else $error("Quad command without quad enable"); // [R5]
  property p_lock; cmd_valid && is_write_op(cmd_opcode) |-> $past(pu_cnt) == 32'h0000_0000;
  endproperty
  a_lock: assert property (p_lock) else $error("Write taken in power-up delay"); // [R18]
  property p_pause_oe; paused |=> io_oe == 4'h0; endproperty
  a_pause_oe: assert property (p_pause_oe) else $error("Driving while paused"); // [R9]
  property p_pause_low; $rose(paused) |-> !$past(s2.sclk); endproperty
  a_pause_low: assert property (p_pause_low) else $error("Pause began with clock high"); // [R10]
  property p_swr; swr_go |=> swr_busy ##1 in_reset[*2]; endproperty
  a_swr: assert property (p_swr) else $error("Soft reset not entered"); // [R12]
  property p_hw; hw_reset |=> in_reset && !write_latch; endproperty
  a_hw: assert property (p_hw) else $error("Hardware reset ignored"); // [R14]
  property p_standby; s2.cs_n && !write_busy |=> standby; endproperty
  a_standby: assert property (p_standby) else $error("Standby missed"); // [R8]
endmodule : sfic_top

//--- testbench/serial_flash_interface_control_tb_top.sv
// Self-checking bench for the serial flash interface control block
`timescale 1ns/1ps
module serial_flash_interface_control_tb_top;
  import sfic_pkg::*;
  localparam int SWR = 50;
  localparam int PWD = 600;
  logic clk = 1'b0;
  logic rst = 1'b1;
  sfic_pins_t pins;
  sfic_cfg_t cfg = '0;
  logic por_active = 1'b1;
  logic write_busy = 1'b0;
  logic region_protected = 1'b0;
  logic tx_enable = 1'b0;
  logic [7:0] tx_byte = 8'h00;
  logic [3:0] io_out;
  logic [3:0] io_oe;
  logic cmd_valid, cmd_refused, rx_valid, write_latch, standby, paused, in_reset;
  logic deep_power_down, abort_pulse;
  logic [7:0] cmd_opcode, rx_byte, r, d, op;
  logic [7:0] ops[16] = '{OP_WRDI, OP_WRSR, OP_PP, OP_SE, OP_BE32, OP_BE64, OP_CE, OP_DPD,
    OP_RDPD, OP_DUAL_OUT, OP_DUAL_IO, OP_DUAL_ID, OP_QUAD_OUT, OP_QUAD_IO, OP_QUAD_WORD,
    OP_QUAD_ID};
  logic [7:0] acc_q[$];
  logic [7:0] rx_q[$];
  logic [7:0] ref_q[$];
  int miscompares = 0;
  int tests_run = 0;
  int rst_cnt = 0;
  int ab_cnt = 0;
  int n;
  integer seed = 32'h9ad2_8eed;
  logic [31:0] rnd;
  bit m_latch = 0;
  bit m_dpd = 0;
  bit ok;
  always #5 clk = ~clk;
  sfic_host_model host (.pins(pins), .io_out(io_out), .io_oe(io_oe));
  sfic_top #(.SW_RESET_CYCLES(SWR), .POWER_UP_WRITE_DELAY_CYCLES(PWD)) dut (.clk(clk),
    .rst(rst), .pins(pins), .cfg(cfg), .por_active(por_active), .write_busy(write_busy),
    .region_protected(region_protected), .tx_enable(tx_enable), .tx_byte(tx_byte),
    .io_out(io_out), .io_oe(io_oe), .cmd_valid(cmd_valid), .cmd_refused(cmd_refused),
    .cmd_opcode(cmd_opcode), .rx_valid(rx_valid), .rx_byte(rx_byte),
    .write_latch(write_latch), .standby(standby), .paused(paused), .in_reset(in_reset),
    .deep_power_down(deep_power_down), .abort_pulse(abort_pulse));
  // ---------------------------------------------------------------
  // Model and checks
  // ---------------------------------------------------------------
  always @(negedge clk) begin
    if (cmd_valid === 1'b1) acc_q.push_back(cmd_opcode);
    if (rx_valid === 1'b1) rx_q.push_back(rx_byte);
    if (cmd_refused === 1'b1) ref_q.push_back(cmd_opcode);
    if (in_reset === 1'b1) rst_cnt++;
    if (abort_pulse === 1'b1) ab_cnt++;
  end
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: %s got %0h expected %0h", $time, what, got, exp);
    end
  endtask : check
  task automatic end_of_test();
    $display("tests_run %0d miscompares %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : end_of_test
  function automatic bit is_wr(logic [7:0] o);
    return o inside {OP_WRSR, OP_PP, OP_SE, OP_BE32, OP_BE64, OP_CE};
  endfunction : is_wr
  function automatic int lanes_of(logic [7:0] o);
    if (o inside {OP_DUAL_OUT, OP_DUAL_IO, OP_DUAL_ID}) return 2;
    return (o inside {OP_QUAD_OUT, OP_QUAD_IO, OP_QUAD_WORD, OP_QUAD_ID}) ? 4 : 1;
  endfunction : lanes_of
  // Latch is dropped by any write opcode outside deep power-down, even a refused one, as the device does
  function automatic bit m_accept(logic [7:0] o);
    bit a;
    if (m_dpd) a = (o == OP_RDPD);
    else if (lanes_of(o) == 4 && !cfg.quad_enable_bit) a = 0;
    else if (o == OP_WRSR && cfg.srp0 && !cfg.srp1 && !cfg.quad_enable_bit && !host.p2) a = 0;
    else if (is_wr(o) && (!m_latch || (region_protected && o != OP_WRSR))) a = 0;
    else a = 1;
    if ((!m_dpd && is_wr(o)) || (a && o == OP_WRDI)) m_latch = 0;
    if (a && o == OP_WREN) m_latch = 1;
    if (a && o == OP_DPD) m_dpd = 1;
    if (a && o == OP_RDPD) m_dpd = 0;
    return a;
  endfunction : m_accept
  task automatic op_frame(input logic [7:0] o, input bit exp);
    acc_q.delete();
    ref_q.delete();
    host.xfer(o, 1, 1'b1, r);
    repeat (3) @(negedge clk);
    check(acc_q.size(), exp, "opcode taken");
    if (exp) check(acc_q[0], o, "opcode value");
  endtask : op_frame
  task automatic cmd(input logic [7:0] o);
    host.select();
    op_frame(o, m_accept(o));
    host.deselect();
  endtask : cmd
  // ---------------------------------------------------------------
  // Sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (12) @(negedge clk);
    rst = 1'b0;
    repeat (5) @(negedge clk);
    op_frame(OP_WRDI, 0);
    check(in_reset, 1, "held in power-on reset");
    por_active = 1'b0;
    repeat (5) @(negedge clk);
    op_frame(OP_WRDI, 0);
    host.deselect();
    host.select();
    op_frame(OP_WREN, 0);
    check(ref_q.size(), 1, "write enable refused");
    host.deselect();
    cmd(OP_WRDI);
    repeat (PWD) @(negedge clk);
    $display("test power_up done");
    for (int i = 0; i < 50; i++) begin
      @(negedge clk);
      rnd = $random(seed);
      op = rnd[4] ? OP_WREN : ops[rnd[3:0]];
      cfg.quad_enable_bit = rnd[5];
      region_protected = rnd[6];
      cfg.srp0 = rnd[7];
      host.p2 = rnd[25];
      host.cpol = rnd[24];
      tx_enable = !is_wr(op);
      tx_byte = rnd[15:8];
      d = rnd[23:16];
      rx_q.delete();
      host.select();
      ok = m_accept(op);
      op_frame(op, ok);
      check(ref_q.size(), !ok, "opcode refused");
      if (!ok) check(ref_q[0], op, "refused opcode");
      if (ok && op != OP_DPD) begin
        host.xfer(d, lanes_of(op), is_wr(op), r);
        repeat (6) @(negedge clk);
        if (is_wr(op)) check(rx_q[0], d, "byte received");
        else check(r, tx_byte, "byte sent");
        n = (lanes_of(op) == 4) ? 4'hf : (lanes_of(op) == 2) ? 4'h3 : 4'h2;
        if (!is_wr(op)) check(host.seen_oe, n, "lanes");
      end
      host.deselect();
      check(write_latch, m_latch, "write latch");
      check(deep_power_down, m_dpd, "deep power-down");
    end
    cmd(OP_RDPD);
    @(negedge clk);
    cfg.quad_enable_bit = 1'b0;
    region_protected = 1'b0;
    cfg.srp0 = 1'b0;
    host.p2 = 1'b1;
    host.cpol = 1'b0;
    write_busy = 1'b1;
    host.select();
    host.deselect();
    check(standby, 0, "standby while busy");
    @(negedge clk);
    write_busy = 1'b0;
    repeat (4) @(negedge clk);
    check(standby, 1, "standby");
    $display("test commands done");
    cmd(OP_WREN);
    rst_cnt = 0;
    // Enable then reset, back to back as the host must issue them
    cmd(OP_RST_EN);
    cmd(OP_RST);
    repeat (SWR) @(negedge clk);
    check(rst_cnt, SWR, "soft reset length");
    check(write_latch, 0, "latch after soft reset");
    m_latch = 0;
    cmd(OP_WREN);
    @(negedge clk);
    cfg.pin_func_sel = 1'b1;
    n = ab_cnt;
    host.select();
    // The reset level outlasts the minimum pulse, since the frame takes longer
    host.p3 = 1'b0;
    op_frame(OP_WRDI, 0);
    check(in_reset, 1, "hardware reset");
    check(ab_cnt - n, 1, "abort on hardware reset");
    host.p3 = 1'b1;
    host.deselect();
    check(write_latch, 0, "latch after hardware reset");
    m_latch = 0;
    @(negedge clk);
    cfg.quad_enable_bit = 1'b1;
    host.p3 = 1'b0;
    repeat (120) @(negedge clk);
    check(in_reset, 0, "reset pin as data");
    host.p3 = 1'b1;
    @(negedge clk);
    cfg = '0;
    tx_enable = 1'b1;
    $display("test resets done");
    host.select();
    op_frame(OP_WRDI, 1);
    rx_q.delete();
    host.p3 = 1'b0;
    repeat (6) @(negedge clk);
    check(paused, 1, "pause entered");
    check(io_oe, 0, "outputs off in pause");
    host.xfer(8'h0f, 2, 1'b1, r);
    host.p3 = 1'b1;
    repeat (6) @(negedge clk);
    check(paused, 0, "pause left");
    host.xfer(8'h5a, 1, 1'b1, r);
    repeat (6) @(negedge clk);
    check(rx_q.size(), 1, "clock ignored in pause");
    check(rx_q[0], 8'h5a, "state kept in pause");
    n = ab_cnt;
    host.p3 = 1'b0;
    repeat (6) @(negedge clk);
    host.deselect();
    host.p3 = 1'b1;
    check(ab_cnt - n, 1, "abort on deselect in pause");
    check(paused, 0, "pause cleared");
    $display("test pause done");
    end_of_test();
  end
  initial begin
    #600_000;
    miscompares++;
    end_of_test();
  end
endmodule : serial_flash_interface_control_tb_top

//--- testbench/sfic_host_model.sv
// Host controller model that drives the serial flash pin bundle
`timescale 1ns/1ps
module sfic_host_model
  import sfic_pkg::*;
(
  output wire sfic_pkg::sfic_pins_t pins,
  input wire logic [3:0] io_out,
  input wire logic [3:0] io_oe
);
  // ---------------------------------------------------------------
  // Pin levels
  // ---------------------------------------------------------------
  // Select starts low so that power-up qualification is exercised
  logic sclk = 1'b0;
  logic cs_n = 1'b0;
  logic p3 = 1'b1;
  logic p2 = 1'b1;
  bit cpol = 1'b0;
  logic q4 = 1'b0;
  logic [3:0] drv = 4'h0;
  logic [3:0] drv_oe = 4'hc;
  logic [1:0] last = 2'h0;
  logic [3:0] seen_oe = 4'h0;
  wire [3:0] hv = q4 ? drv : {p3, p2, drv[1:0]};
  // Released lines 2 and 3 are pulled up; lines 0 and 1 show a changing pattern
  wire [3:0] io = (io_oe & io_out) | (~io_oe & drv_oe & hv) | (~io_oe & ~drv_oe & {2'h3, ~last});
  assign pins = {sclk, cs_n, io};
  always @(posedge sclk) last <= io[1:0];
  task automatic select();
    sclk = cpol;
    #50 cs_n = 1'b0;
    #50;
  endtask : select
  // Select stays low while paused unless a scenario aborts on purpose
  task automatic deselect();
    #50 cs_n = 1'b1;
    #250;
  endtask : deselect
  task automatic xfer(input logic [7:0] b, input int ln, input logic drive, output logic [7:0] r);
    logic [7:0] sh;
    logic [3:0] m;
    m = (ln == 4) ? 4'hf : (ln == 2) ? 4'h3 : 4'h1;
    r = 8'h00;
    seen_oe = 4'h0;
    q4 = (ln == 4);
    for (int i = 0; i < 8 / ln; i++) begin
      sh = b << (i * ln);
      drv = sh[7:4] >> (4 - ln);
      drv_oe = drive ? (q4 ? 4'hf : {2'h3, m[1:0]}) : (q4 ? 4'h0 : 4'hc);
      // Mode 3 leads each bit with the fall and parks the clock high
      sclk = 1'b0;
      #62.5 sclk = 1'b1;
      r = (r << ln) | ((ln == 1) ? {7'h0, io[1]} : {4'h0, io & m});
      seen_oe = seen_oe | io_oe;
      #62.5 sclk = cpol;
    end
    q4 = 1'b0;
    drv_oe = 4'hc;
  endtask : xfer
endmodule : sfic_host_model
